// ### rtl/lsf_pkg.sv
package lsf_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_PER_US     = CLK_HZ / 1_000_000;
  localparam int CNT_W          = 20;             // holds eight bit times at 2,400 bps
  localparam int ACQ_TIME_US    = 7500;           // position acquisition after reset
  localparam int ACQ_CYCLES     = ACQ_TIME_US * CLK_PER_US;
  localparam int DRV_DLY_MIN_US = 416;            // driver switch-on delay window
  localparam int DRV_DLY_MAX_US = 1250;
  localparam int DRV_DLY_CYCLES = DRV_DLY_MIN_US * CLK_PER_US;
  localparam int STBY_BITS      = 25000;          // idle bit times before standby
  localparam int BREAK_BITS     = 11;             // least low time of a break
  localparam int HOLDOFF_BITS   = 1;              // blind time after a break
  localparam int BRK_TMO_BITS   = 20;             // wait for the next falling edge
  localparam int RATE_BASE_BPS  = 2400;
  localparam int PROV_SHIFT     = 3;              // four periods hold eight bits

  // ---------------------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SYNC_LAST_EDGE = 2'h3;
  localparam logic [3:0] ID_BITS        = 4'hA;   // start, six id, two parity, stop
  localparam int POS_START = 0;
  localparam int POS_ID0   = 1;
  localparam int POS_ID4   = 5;
  localparam int POS_ID5   = 6;
  localparam int POS_P0    = 7;
  localparam int POS_STOP  = 9;

  // status byte bit positions
  localparam int ST_OVERCUR  = 0;
  localparam int ST_STOPPED  = 1;
  localparam int ST_FORWARD  = 2;
  localparam int ST_REVERSE  = 3;
  localparam int ST_PARITY   = 4;
  localparam int ST_OVERTEMP = 5;
  localparam int ST_CHECKSUM = 6;
  localparam int ST_OVERVOLT = 7;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_STATE  = 4'h4;
  localparam logic [3:0] ADR_PERIOD = 4'h8;
  localparam logic [3:0] ADR_CLEAR  = 4'hC;
  localparam int CLR_PARITY = 0;
  localparam int CLR_ADJUST = 1;

  typedef enum logic [3:0] {
    ST_STANDBY, ST_ACQ, ST_IDLE, ST_BRK_LOW, ST_BRK_WAIT, ST_SYNC, ST_ID_WAIT, ST_ID_RX
  } lsf_state_t;

  // oscillator bit period for the selected rate
  function automatic logic [CNT_W-1:0] lsf_nominal_period(input logic [1:0] code);
    return CNT_W'(CLK_HZ / (RATE_BASE_BPS << code));
  endfunction

  // bit times to clock cycles at a given bit period
  function automatic logic [CNT_W-1:0] lsf_bits_to_cyc(input int n,
                                                       input logic [CNT_W-1:0] per);
    return CNT_W'(n * int'(per));
  endfunction

  // identifier parity check over six id bits and two parity bits
  function automatic logic lsf_parity_ok(input logic [5:0] id, input logic [1:0] p);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return (p[0] == p0) && (p[1] == p1);
  endfunction

endpackage

// ### rtl/lsf_tick_if.sv
`timescale 1ns/1ps
interface lsf_tick_if;
  import lsf_pkg::*;
  logic             restart;
  logic [CNT_W-1:0] period;
  logic             half_tick;
  logic             full_tick;
  modport ctrl  (output restart, output period, input half_tick, input full_tick);
  modport timer (input restart, input period, output half_tick, output full_tick);
endinterface

// ### rtl/lsf_bit_timer.sv
`timescale 1ns/1ps
module lsf_bit_timer
  import lsf_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // timing link to the frame logic
  lsf_tick_if.timer tk
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } lsf_tmr_s_t;

  lsf_tmr_s_t s_q;
  lsf_tmr_s_t s_d;

  // ---------------------------------------------------------------------------
  // bit period counter
  // ---------------------------------------------------------------------------
  // count to the full period, sample point at half, clear at full
  always_comb
  begin
    s_d = s_q;
    if (tk.restart)
      s_d.cnt = '0;
    else if (s_q.cnt >= tk.period - 1'b1)
      s_d.cnt = '0; // RL13
    else
      s_d.cnt = s_q.cnt + 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // tick pulses
  assign tk.half_tick = !tk.restart && (s_q.cnt == (tk.period >> 1)); // RL13
  assign tk.full_tick = !tk.restart && (s_q.cnt == tk.period - 1'b1);

endmodule

// ### rtl/lsf_frame_front.sv
// What this block does
// (RL1) status byte carries fault, motion and error flags
// (RL2) ignore commands for 7.5 ms after reset
// (RL3) master waits 10 ms after wake signal
// (RL4) driver on 416 to 1,250 us after command
// (RL5) standby after 25,000 idle high bit times
// (RL6) standby waits for motor; never while low
// (RL7) low bus in standby wakes, enables regulator
// (RL8) rate pins pick 2,400 to 19,200 bps
// (RL9) break is low longer than 11 bits
// (RL10) blind 1 to 13 bits after break
// (RL11) no falling edge in time: drop frame
// (RL12) time four sync periods, period is eighth
// (RL13) sample id bits at half period, ten bits
// (RL14) parity pass adopts measured bit period
// (RL15) parity fail: wait; flag if addressed
// (RL16) address match selects transmit or receive mode
// (RL17) sixth id bit set: ignore identifier
// (RL18) communication mode starts as transmit request
// (RL19) keep last adjusted period after failures
// (RL20) timing starts at break edge, oscillator first
// (RL21) master sends break 80h, sync 55h
// (RL22) tolerate 15 percent idle timeout error
// (RL23) parity bits from id bit exclusive-ors
// (RL24) counter holds eight bits at slowest rate
`timescale 1ns/1ps
module lsf_frame_front
  import lsf_pkg::*;
#(
  parameter int ACQ_CYC   = ACQ_CYCLES,
  parameter int DRV_DLY   = DRV_DLY_CYCLES,
  parameter int STBY_BITC = STBY_BITS
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bus receiver
  input  wire logic        received_line,
  // strap pins
  input  wire logic        rate_select_lo,
  input  wire logic        rate_select_hi,
  input  wire logic        node_addr_bit_a,
  input  wire logic        node_addr_bit_b,
  input  wire logic        node_addr_bit_c,
  input  wire logic        node_addr_bit_d,
  // motor control side
  input  wire logic        cmd_start,
  input  wire logic        cmd_forward,
  input  wire logic        motor_done,
  input  wire logic        overcurrent,
  input  wire logic        overtemp,
  input  wire logic        overvoltage,
  input  wire logic        checksum_err,
  // frame results and outputs
  output logic             regulator_en,
  output logic             comm_mode_rx,
  output logic             frame_hit,
  output logic [7:0]       tx_status,
  output logic             driver_out_a,
  output logic             driver_out_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  typedef struct packed {
    lsf_state_t       state;
    logic [CNT_W-1:0] cnt;       // cycles in the current phase
    logic [CNT_W-1:0] meas;      // RL24
    logic [CNT_W-1:0] prov;      // provisional bit period
    logic [CNT_W-1:0] adj_per;   // adjusted bit period
    logic             adj_valid;
    logic [1:0]       edges;
    logic [9:0]       shreg;
    logic [3:0]       nbits;
    logic             bus_prev;
    logic [CNT_W-1:0] idle_cyc;
    logic [15:0]      idle_bits;
    logic             drv_pend;
    logic [CNT_W-1:0] dly;
    logic             drv_fwd;
    logic             drv_a;
    logic             drv_b;
    logic             mode_rx;
    logic             hit;
    logic             par_err;
    logic [7:0]       status;
    logic             ack;
    logic [31:0]      rdata;
  } lsf_main_s_t;

  localparam lsf_main_s_t RST_S = '{state: ST_ACQ, bus_prev: 1'b1, default: '0};

  lsf_main_s_t      s_q;
  lsf_main_s_t      s_d;
  lsf_tick_if       tk ();
  logic             fall;
  logic             rise;
  logic [CNT_W-1:0] op_per;
  logic [CNT_W-1:0] brk_lim;
  logic [CNT_W-1:0] hold_lim;
  logic [CNT_W-1:0] tmo_lim;
  logic [3:0]       node_addr;
  logic             drv_active;
  logic             cmd_ok;
  logic             wb_req;
  logic             wb_wr;
  logic             id_eval;
  logic             frame_ok;
  logic             par_ok;
  logic             addr_hit;
  logic             listed;

  // ---------------------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------------------
  lsf_bit_timer u_timer (
    .clk (clk),
    .rst (rst),
    .tk  (tk.timer)
  );

  // oscillator period until the first adjustment, then the adjusted one
  assign op_per     = s_q.adj_valid ? s_q.adj_per
                                    : lsf_nominal_period({rate_select_hi, rate_select_lo}); // RL8 RL19 RL20
  assign brk_lim    = lsf_bits_to_cyc(BREAK_BITS, op_per);
  assign hold_lim   = lsf_bits_to_cyc(HOLDOFF_BITS, op_per);
  assign tmo_lim    = lsf_bits_to_cyc(BRK_TMO_BITS, op_per);
  assign tk.period  = s_q.prov;
  assign tk.restart = (s_q.state == ST_ID_WAIT) && fall;

  // line edges and frame decode
  assign fall       = s_q.bus_prev && !received_line;
  assign rise       = !s_q.bus_prev && received_line;
  assign node_addr  = {node_addr_bit_d, node_addr_bit_c, node_addr_bit_b, node_addr_bit_a};
  assign id_eval    = (s_q.state == ST_ID_RX) && (s_q.nbits == ID_BITS);
  assign frame_ok   = !s_q.shreg[POS_START] && s_q.shreg[POS_STOP];
  assign par_ok     = lsf_parity_ok(s_q.shreg[POS_ID0 +: 6], s_q.shreg[POS_P0 +: 2]); // RL23
  assign addr_hit   = s_q.shreg[POS_ID0 +: 4] == node_addr;
  assign listed     = !s_q.shreg[POS_ID5]; // RL17
  assign drv_active = s_q.drv_pend || s_q.drv_a || s_q.drv_b;
  assign cmd_ok     = (s_q.state != ST_STANDBY) && (s_q.state != ST_ACQ) && !drv_active; // RL2
  assign wb_req     = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wb_wr      = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack
                      && (wb_adr_i == ADR_CLEAR) && wb_sel_i[0];

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_d          = s_q;
    s_d.bus_prev = received_line;
    s_d.hit      = 1'b0;
    s_d.ack      = wb_req;

    // idle monitor: bit times of high line with no transition
    if (fall || rise || !received_line)
    begin
      s_d.idle_cyc  = '0;
      s_d.idle_bits = '0;
    end
    else if (s_q.idle_cyc >= op_per - 1'b1)
    begin
      s_d.idle_cyc = '0;
      if (s_q.idle_bits != '1)
        s_d.idle_bits = s_q.idle_bits + 1'b1;
    end
    else
      s_d.idle_cyc = s_q.idle_cyc + 1'b1;

    // software clears, overridden below by a same-cycle set
    if (wb_wr && wb_dat_i[CLR_PARITY])
      s_d.par_err = 1'b0;
    if (wb_wr && wb_dat_i[CLR_ADJUST])
      s_d.adj_valid = 1'b0;

    // frame sequencer
    case (s_q.state)
      ST_STANDBY:
      begin
        if (!received_line)
        begin
          s_d.state = ST_ACQ; // RL7
          s_d.cnt   = '0;
        end
      end
      ST_ACQ:
      begin
        if (s_q.cnt >= CNT_W'(ACQ_CYC - 1))
        begin
          s_d.state = ST_IDLE; // RL2
          s_d.cnt   = '0;
        end
        else
          s_d.cnt = s_q.cnt + 1'b1;
      end
      ST_IDLE:
      begin
        if (fall)
        begin
          s_d.state = ST_BRK_LOW; // RL20
          s_d.cnt   = '0;
        end
      end
      ST_BRK_LOW:
      begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (rise)
        begin
          s_d.state = (s_q.cnt > brk_lim) ? ST_BRK_WAIT : ST_IDLE; // RL9
          s_d.cnt   = '0;
        end
      end
      ST_BRK_WAIT:
      begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (fall && (s_q.cnt >= hold_lim))
        begin
          s_d.state = ST_SYNC; // RL10
          s_d.meas  = CNT_W'(1'b1); // the edge cycle counts too
          s_d.edges = '0;
        end
        else if (s_q.cnt >= tmo_lim)
          s_d.state = ST_IDLE; // RL11
      end
      ST_SYNC:
      begin
        s_d.meas = s_q.meas + 1'b1;
        if (fall)
        begin
          if (s_q.edges == SYNC_LAST_EDGE)
          begin
            s_d.state = ST_ID_WAIT; // RL12
            s_d.prov  = s_q.meas >> PROV_SHIFT;
            s_d.cnt   = '0;
          end
          else
            s_d.edges = s_q.edges + 1'b1;
        end
        else if (s_q.meas == '1)
          s_d.state = ST_IDLE;
      end
      ST_ID_WAIT:
      begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (fall)
        begin
          s_d.state = ST_ID_RX; // RL12
          s_d.nbits = '0;
        end
        else if (s_q.cnt >= tmo_lim)
          s_d.state = ST_IDLE; // RL11
      end
      ST_ID_RX:
      begin
        if (id_eval)
        begin
          s_d.state = ST_IDLE;
          if (frame_ok && par_ok)
          begin
            s_d.adj_per   = s_q.prov; // RL14
            s_d.adj_valid = 1'b1; // RL19
            if (listed && addr_hit)
            begin
              s_d.mode_rx = s_q.shreg[POS_ID4]; // RL16
              s_d.hit     = 1'b1;
            end
          end
          else if (listed && addr_hit)
            s_d.par_err = 1'b1; // RL15
        end
        else if (tk.half_tick)
        begin
          s_d.shreg = {received_line, s_q.shreg[9:1]}; // RL13
          s_d.nbits = s_q.nbits + 1'b1;
        end
      end
      default:
        s_d.state = ST_IDLE;
    endcase

    // standby entry: long idle high, motor finished
    if ((s_q.state != ST_STANDBY) && (s_q.idle_bits >= 16'(STBY_BITC))
        && received_line && !drv_active)
    begin
      s_d.state = ST_STANDBY; // RL5 RL6 RL22
      s_d.cnt   = '0;
    end

    // motor driver switch-on delay
    if (s_q.drv_pend)
    begin
      if (s_q.dly >= CNT_W'(DRV_DLY - 1))
      begin
        s_d.drv_pend = 1'b0; // RL4
        s_d.drv_a    = s_q.drv_fwd;
        s_d.drv_b    = !s_q.drv_fwd;
      end
      else
        s_d.dly = s_q.dly + 1'b1;
    end
    else if ((s_q.drv_a || s_q.drv_b) && motor_done)
    begin
      s_d.drv_a = 1'b0;
      s_d.drv_b = 1'b0;
    end
    else if (cmd_start && cmd_ok)
    begin
      s_d.drv_pend = 1'b1;
      s_d.dly      = '0;
      s_d.drv_fwd  = cmd_forward;
    end

    // status byte for transmission requests
    s_d.status[ST_OVERCUR]  = overcurrent; // RL1
    s_d.status[ST_STOPPED]  = !s_q.drv_a && !s_q.drv_b;
    s_d.status[ST_FORWARD]  = s_q.drv_a;
    s_d.status[ST_REVERSE]  = s_q.drv_b;
    s_d.status[ST_PARITY]   = s_q.par_err;
    s_d.status[ST_OVERTEMP] = overtemp;
    s_d.status[ST_CHECKSUM] = checksum_err;
    s_d.status[ST_OVERVOLT] = overvoltage;

    // register read data, held through the answer
    if (wb_req)
    begin
      case (wb_adr_i)
        ADR_STATUS: s_d.rdata = {24'h000000, s_q.status};
        ADR_STATE:  s_d.rdata = {25'h0000000, s_q.adj_valid, s_q.mode_rx, s_q.par_err,
                                 s_q.state};
        ADR_PERIOD: s_d.rdata = {{(32 - CNT_W){1'b0}}, op_per};
        default:    s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= RST_S; // RL18
    else
      s_q <= s_d;
  end

  // outputs
  assign regulator_en = s_q.state != ST_STANDBY; // RL7
  assign comm_mode_rx = s_q.mode_rx;
  assign frame_hit    = s_q.hit;
  assign tx_status    = s_q.status;
  assign driver_out_a = s_q.drv_a;
  assign driver_out_b = s_q.drv_b;
  assign wb_dat_o     = s_q.rdata;
  assign wb_ack_o     = s_q.ack;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_status_motion: assert property (!$past(rst)  // RL1
    |-> (tx_status[ST_FORWARD] == $past(s_q.drv_a))
    && (tx_status[ST_STOPPED] == !($past(s_q.drv_a) || $past(s_q.drv_b))))
    else $error("status byte motion bits wrong");

  a_acq_discard: assert property ((s_q.state == ST_ACQ) && !drv_active  // RL2
    |=> !s_q.drv_pend)
    else $error("command taken during acquisition");

  a_drv_delay: assert property ($rose(s_q.drv_pend) |-> !s_q.drv_a && !s_q.drv_b) // RL4
    else $error("driver on before delay");

  a_drv_count: assert property ($rose(s_q.drv_a || s_q.drv_b)  // RL4
    |-> $past(s_q.dly) == CNT_W'(DRV_DLY - 1))
    else $error("driver on at wrong delay");

  a_stby_entry: assert property ($rose(s_q.state == ST_STANDBY)  // RL6
    |-> $past(received_line) && !$past(drv_active))
    else $error("standby entered while low or driving");

  a_wake_bus: assert property ((s_q.state == ST_STANDBY) && !received_line  // RL7
    |=> (s_q.state == ST_ACQ) && regulator_en)
    else $error("no wake on low bus");

  a_break_len: assert property ((s_q.state == ST_BRK_LOW) && rise && (s_q.cnt <= brk_lim) // RL9
    |=> s_q.state != ST_BRK_WAIT)
    else $error("short low taken as break");

  a_brk_tmo: assert property ((s_q.state == ST_BRK_WAIT) && received_line  // RL11
    && (s_q.cnt >= tmo_lim) && (s_q.idle_bits < 16'(STBY_BITC)) |=> s_q.state == ST_IDLE)
    else $error("break wait did not time out");

  a_sync_period: assert property ((s_q.state == ST_SYNC) && fall  // RL12
    && (s_q.edges == SYNC_LAST_EDGE) |=> s_q.prov == ($past(s_q.meas) >> PROV_SHIFT))
    else $error("provisional period wrong");

  a_id_adopt: assert property (id_eval && frame_ok && par_ok  // RL14
    |=> s_q.adj_valid && (s_q.adj_per == $past(s_q.prov)))
    else $error("period not adopted");

  a_par_flag: assert property (id_eval && !(frame_ok && par_ok) && listed && addr_hit // RL15
    |=> s_q.par_err && !frame_hit)
    else $error("parity flag not set");

  a_mode_sel: assert property (frame_hit  // RL16
    |-> comm_mode_rx == $past(s_q.shreg[POS_ID4]) && !$past(s_q.shreg[POS_ID5]))
    else $error("mode selection wrong");

endmodule

// ### verification/lsf_lin_master.sv
`timescale 1ns/1ps
// ----------------------------------------------
// bus master model: break, sync and identifier
// ----------------------------------------------
module lsf_lin_master
(
  // clock
  input  wire logic clk,
  // bus line, recessive high
  output logic      line
);
  // idle recessive
  initial line = 1'h1;

  // one byte, lsb first, with start and stop
  task automatic send_byte(input logic [7:0] b, input int bit_cyc);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk) line <= f[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
  endtask

  // header: break byte at half rate, sync byte, protected identifier
  task automatic send_frame(input logic [5:0] id, input logic bad, input int brk,
                            input int bitc);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4] ^ bad;
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    send_byte(8'h80, 2 * brk);
    send_byte(8'h55, bitc);
    send_byte({p1, p0, id}, bitc);
  endtask

  // short dominant pulse that wakes sleeping nodes
  task automatic wake(input int n);
    @(posedge clk) line <= 1'h0;
    repeat (n) @(posedge clk);
    line <= 1'h1;
  endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("mismatch at %0t: got %h expected %h", $time, a, b); \
    end \
  end
module tb_top;
  import lsf_pkg::*;
  // ----------------------------------------------
  // setup
  // ----------------------------------------------
  localparam int ACQ = 200;
  localparam int DLY = 50;
  localparam int STB = 20;
  localparam int BIT = 100;
  localparam int BRK = 1953;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        line;
  logic [3:0]  node = 4'h5;
  logic [1:0]  rate = 2'h3;
  logic        cmd_start = 1'h0;
  logic        cmd_fwd = 1'h0;
  logic        motor_done = 1'h0;
  logic [3:0]  flt = 4'h0;
  logic        wb_cyc = 1'h0;
  logic        wb_stb = 1'h0;
  logic        wb_we = 1'h0;
  logic [3:0]  wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        regulator_en, comm_mode_rx, frame_hit, drv_a, drv_b;
  logic [7:0]  tx_status;
  logic [31:0] rd;
  int          errors = 0;
  int          checked = 0;
  int          hits = 0;
  int          n;
  logic [5:0]  fid [4] = '{6'h05, 6'h25, 6'h06, 6'h05};
  logic        fbad [4] = '{1'h1, 1'h0, 1'h0, 1'h0};
  int          fhit [4] = '{1, 1, 1, 2};
  logic        fmod [4] = '{1'h1, 1'h1, 1'h1, 1'h0};

  // clock
  always #10 clk = ~clk;

  // count accepted frames
  always @(posedge clk)
    if (frame_hit === 1'h1)
      hits++;

  lsf_lin_master lsf_lin_master_inst (.clk(clk), .line(line));

  lsf_frame_front #(.ACQ_CYC(ACQ), .DRV_DLY(DLY), .STBY_BITC(STB)) lsf_frame_front_inst (
    .clk(clk), .rst(rst), .received_line(line),
    .rate_select_lo(rate[0]), .rate_select_hi(rate[1]),
    .node_addr_bit_a(node[0]), .node_addr_bit_b(node[1]),
    .node_addr_bit_c(node[2]), .node_addr_bit_d(node[3]),
    .cmd_start(cmd_start), .cmd_forward(cmd_fwd), .motor_done(motor_done),
    .overcurrent(flt[0]), .overtemp(flt[1]), .overvoltage(flt[2]), .checksum_err(flt[3]),
    .regulator_en(regulator_en), .comm_mode_rx(comm_mode_rx), .frame_hit(frame_hit),
    .tx_status(tx_status), .driver_out_a(drv_a), .driver_out_b(drv_b),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  // ----------------------------------------------
  // tasks
  // ----------------------------------------------
  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic [3:0] a, input logic we, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wb_ack_o !== 1'h1 && k < 20);
    rd = wb_dat_o;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    if (k >= 20)
    begin
      errors++;
      $display("mismatch at %0t: no bus answer", $time);
      results();
    end
  endtask

  task automatic wb_rd(input logic [3:0] a, input logic [31:0] exp);
    wb_xfer(a, 1'h0, 32'h0);
    `CHK(rd, exp);
  endtask

  task automatic pulse_cmd(input logic fwd);
    @(posedge clk);
    cmd_start <= 1'h1;
    cmd_fwd   <= fwd;
    @(posedge clk);
    cmd_start <= 1'h0;
  endtask

  // ----------------------------------------------
  // sequence
  // ----------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    #1 `CHK(tx_status, 8'h02);
    `CHK(comm_mode_rx, 1'h0);
    wb_rd(ADR_STATE, 32'h1);
    pulse_cmd(1'h1);
    repeat (DLY + 5) @(posedge clk);
    #1 `CHK(drv_a, 1'h0);
    repeat (ACQ) @(posedge clk);
    flt <= 4'hF;
    repeat (2) @(posedge clk);
    #1 `CHK(tx_status, 8'hE3);
    wb_rd(ADR_STATUS, 32'hE3);
    flt <= 4'h0;
    wb_rd(4'h2, 32'h0);
    wb_xfer(ADR_STATUS, 1'h1, 32'hFF);
    wb_rd(ADR_STATUS, 32'h02);
    // first header, break timed on the oscillator
    lsf_lin_master_inst.send_frame(6'h15, 1'h0, BRK, BIT);
    repeat (3) @(posedge clk);
    #1 `CHK(hits, 1);
    `CHK(comm_mode_rx, 1'h1);
    wb_rd(ADR_PERIOD, 32'h64);
    wb_rd(ADR_STATE, 32'h62);
    // forward then reverse, the second held past the idle limit
    for (int d = 1; d >= 0; d--)
    begin
      pulse_cmd(d[0]);
      repeat (DLY - 1) @(posedge clk);
      #1 `CHK({drv_a, drv_b}, 2'h0);
      repeat (3) @(posedge clk);
      #1 `CHK({drv_a, drv_b}, d ? 2'h2 : 2'h1);
      `CHK(tx_status, d ? 8'h04 : 8'h08);
      if (d == 0)
        repeat (STB * BIT + 100) @(posedge clk);
      #1 `CHK(regulator_en, 1'h1);
      @(posedge clk);
      motor_done <= 1'h1;
      @(posedge clk);
      motor_done <= 1'h0;
      repeat (3) @(posedge clk);
      #1 `CHK(tx_status, 8'h02);
    end
    n = 0;
    while (regulator_en !== 1'h0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(regulator_en, 1'h0);
    if (n >= 3000)
    begin
      errors++;
      $display("mismatch at %0t: no standby entry", $time);
      results();
    end
    wb_rd(ADR_STATE, 32'h60);
    lsf_lin_master_inst.wake(5);
    #1 `CHK(regulator_en, 1'h1);
    wb_rd(ADR_STATE, 32'h61);
    repeat (ACQ + 50) @(posedge clk);
    // a low shorter than a break leaves the sequencer idle
    lsf_lin_master_inst.wake(5 * BIT);
    wb_rd(ADR_STATE, 32'h62);
    // fast headers on the adjusted period
    for (int i = 0; i < 4; i++)
    begin
      lsf_lin_master_inst.send_frame(fid[i], fbad[i], BIT, BIT);
      repeat (3) @(posedge clk);
      #1 `CHK(hits, fhit[i]);
      `CHK(comm_mode_rx, fmod[i]);
    end
    `CHK(tx_status, 8'h12);
    wb_rd(ADR_PERIOD, 32'h64);
    wb_rd(ADR_STATE, 32'h52);
    wb_xfer(ADR_CLEAR, 1'h1, 32'h1);
    wb_rd(ADR_STATE, 32'h42);
    wb_xfer(ADR_CLEAR, 1'h1, 32'h2);
    wb_rd(ADR_PERIOD, 32'hA2C);
    // the other rate strap codes on the oscillator period
    rate <= 2'h1;
    wb_rd(ADR_PERIOD, 32'h28B0);
    rate <= 2'h2;
    wb_rd(ADR_PERIOD, 32'h1458);
    rate <= 2'h0;
    wb_rd(ADR_PERIOD, 32'h5161);
    results();
  end

  // overall watchdog
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: run too long", $time);
    results();
  end
endmodule
